/* File: rtc_pkg.sv */
// Purpose: shared constants and types for the time-of-day counter
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: register byte address is four times the register index
package rtc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int RTC_ADDR_W = 12;
  localparam logic [RTC_ADDR_W-1:0] RTC_IDX_SEC = 12'h118;
  localparam logic [RTC_ADDR_W-1:0] RTC_IDX_MIN = 12'h119;
  localparam logic [RTC_ADDR_W-1:0] RTC_IDX_HR = 12'h11a;
  localparam logic [RTC_ADDR_W-1:0] RTC_IDX_WK = 12'h11b;
  localparam logic [RTC_ADDR_W-1:0] RTC_IDX_CR1 = 12'h11c;
  localparam logic [RTC_ADDR_W-1:0] RTC_IDX_IEN = 12'h11d;
  localparam logic [1:0] RTC_IDX_SHIFT = 2'h2;
  localparam logic [7:0] RTC_REG_RESET = 8'h00;

  // ****************************************
  // clock_control_one bit positions
  // ****************************************
  localparam int RTC_CR_IND = 1;
  localparam int RTC_CR_GATE = 2;
  localparam int RTC_CR_INT = 3;
  localparam int RTC_CR_SOFT = 4;
  localparam int RTC_CR_PM = 5;
  localparam int RTC_CR_FMT = 6;
  localparam int RTC_CR_RUN = 7;
  localparam int RTC_BUSY_BIT = 7;
  localparam logic [5:0] RTC_IEN_MASK = 6'h3f;

  // ****************************************
  // counting limits
  // ****************************************
  localparam logic [3:0] RTC_LOW_MAX = 4'h9;
  localparam logic [2:0] RTC_TENS_MAX = 3'h5;
  localparam logic [1:0] RTC_H12_HIGH_MAX = 2'h1;
  localparam logic [3:0] RTC_H12_LOW_MAX = 4'h1;
  localparam logic [1:0] RTC_H24_HIGH_MAX = 2'h2;
  localparam logic [3:0] RTC_H24_LOW_MAX = 4'h3;
  localparam logic [2:0] RTC_WK_SAT = 3'h6;
  localparam logic [2:0] RTC_WK_SUN = 3'h0;

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] weekday_field;
    logic [1:0] hour_high_digit;
    logic [3:0] hour_low_digit;
    logic [2:0] min_high_digit;
    logic [3:0] min_low_digit;
    logic [2:0] sec_high_digit;
    logic [3:0] sec_low_digit;
  } rtc_time_s;

  typedef struct packed {
    logic run_request;
    logic hour_format_select;
    logic afternoon_flag;
    logic soft_clear;
    logic int_timing;
    logic clock_out_gate;
  } rtc_ctrl_s;

endpackage : rtc_pkg

/* File: rtc_tod_counter.sv */
// Purpose: time-of-day counter in clock mode with AXI4-Lite registers
// Assumes: subclock arrives asynchronously and is much slower than aclk
// Notes: one second is subclock/4, /2, /16, /256
// Functional notes
// - low seconds digit counts BCD 0-9 per tick, carries on rollover.
// - high seconds digit counts 0-5, then wraps and carries to minutes.
// - low minutes digit counts BCD 0-9 per minute carry, carries on rollover.
// - high minutes digit counts 0-5, then wraps and carries to hours.
// - low hours digit counts BCD 0-9 per hour carry, carries on rollover.
// - high hours digit counts 0-1 in 12-hour, 0-2 in 24-hour mode.
// - bit 7 of the four time registers reads busy while updating.
// - weekday 001b..110b is Monday..Saturday; software never writes 111b.
// - unassigned bits read zero.
// - control bit 1 reads counting status, read only.
// - control bit 2 enables clock output on the timer output pin.
// - writing 1 then 0 to control bit 4 clears time, enables, flags.
// - same sequence clears the 8-bit and 4-bit counters.
// - control bit 5 is a.m. 0, p.m. 1 in 12-hour mode.
// - hardware updates the a.m./p.m. flag while counting.
// - control bit 6 selects 12-hour (0) or 24-hour (1) operation.
// - control bit 7 starts counting on 1, stops on 0.
// - second tick comes from subclock/4 through /2, 4-bit, 8-bit counters.
// - weekday 000b is Sunday and a selectable interrupt condition.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtc_tod_counter #(
  parameter int NIB_W = 4,
  parameter int BYTE_W = 8
) (
  input wire logic aclk, // 250 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic subclock, // asynchronous subclock pin
  input wire logic [rtc_pkg::RTC_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [rtc_pkg::RTC_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic timer_output_pin, // gated 1 Hz clock output
  output logic [5:0] interrupt_enable_reg // enable bits for the interrupt unit
);
  import rtc_pkg::*;

  // ****************************************
  // subclock synchroniser and prescaler
  // ****************************************
  logic sub_meta_q, sub_sync_q, sub_prev_q;
  logic [1:0] div4_q;
  logic div2_q;
  logic [NIB_W-1:0] nib_q;
  logic [BYTE_W-1:0] byte_q;
  logic sub_rise, tick4, nib_wrap, sec_tick;
  logic counting_indicator_q;
  logic busy_q;
  logic clear_now;
  rtc_time_s time_q, time_d;
  rtc_ctrl_s ctrl_q;
  logic pm_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else begin
      sub_meta_q <= subclock;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  assign sub_rise = sub_sync_q & ~sub_prev_q;
  assign tick4 = sub_rise & (&div4_q);
  assign nib_wrap = tick4 & counting_indicator_q & div2_q & (&nib_q);
  assign sec_tick = nib_wrap & (&byte_q);

  // the /4 divider runs free so start and stop line up with its edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div4_q <= 2'h0;
    end else if (sub_rise) begin
      div4_q <= div4_q + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear_now) begin
      div2_q <= 1'b0;
      nib_q <= '0;
      byte_q <= '0;
    end else if (tick4 && counting_indicator_q) begin
      div2_q <= ~div2_q;
      if (div2_q) begin
        nib_q <= nib_q + {{(NIB_W-1){1'b0}}, 1'b1};
      end
      if (nib_wrap) begin
        byte_q <= byte_q + {{(BYTE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // status follows the run bit only on a subclock/4 tick, so software sees the real state
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_now) begin
      counting_indicator_q <= 1'b0;
    end else if (tick4) begin
      counting_indicator_q <= ctrl_q.run_request;
    end
  end

  // busy is the tick delayed one cycle, so it covers only the update cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_now) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= sec_tick;
    end
  end

  // ****************************************
  // time cascade
  // ****************************************
  always_comb begin
    logic c_min, c_hr, c_day, last_hr;
    time_d = time_q;
    pm_d = ctrl_q.afternoon_flag;
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    last_hr = 1'b0;
    if (time_q.sec_low_digit >= RTC_LOW_MAX) begin
      time_d.sec_low_digit = 4'h0;
      if (time_q.sec_high_digit >= RTC_TENS_MAX) begin
        time_d.sec_high_digit = 3'h0;
        c_min = 1'b1;
      end else begin
        time_d.sec_high_digit = time_q.sec_high_digit + 3'h1;
      end
    end else begin
      time_d.sec_low_digit = time_q.sec_low_digit + 4'h1;
    end
    if (c_min) begin
      if (time_q.min_low_digit >= RTC_LOW_MAX) begin
        time_d.min_low_digit = 4'h0;
        if (time_q.min_high_digit >= RTC_TENS_MAX) begin
          time_d.min_high_digit = 3'h0;
          c_hr = 1'b1;
        end else begin
          time_d.min_high_digit = time_q.min_high_digit + 3'h1;
        end
      end else begin
        time_d.min_low_digit = time_q.min_low_digit + 4'h1;
      end
    end
    if (ctrl_q.hour_format_select) begin
      last_hr = time_q.hour_high_digit >= RTC_H24_HIGH_MAX && time_q.hour_low_digit >= RTC_H24_LOW_MAX;
    end else begin
      last_hr = time_q.hour_high_digit >= RTC_H12_HIGH_MAX && time_q.hour_low_digit >= RTC_H12_LOW_MAX;
    end
    if (c_hr) begin
      if (last_hr) begin
        time_d.hour_high_digit = 2'h0;
        time_d.hour_low_digit = 4'h0;
        if (ctrl_q.hour_format_select) begin
          c_day = 1'b1;
        end else begin
          pm_d = ~ctrl_q.afternoon_flag;
          c_day = ctrl_q.afternoon_flag;
        end
      end else if (time_q.hour_low_digit >= RTC_LOW_MAX) begin
        time_d.hour_low_digit = 4'h0;
        time_d.hour_high_digit = time_q.hour_high_digit + 2'h1;
      end else begin
        time_d.hour_low_digit = time_q.hour_low_digit + 4'h1;
      end
    end
    if (c_day) begin
      if (time_q.weekday_field >= RTC_WK_SAT) begin
        time_d.weekday_field = RTC_WK_SUN;
      end else begin
        time_d.weekday_field = time_q.weekday_field + 3'h1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_held_q, w_held_q;
  logic [RTC_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [RTC_ADDR_W-1:0] widx, ridx;
  logic wr_hit, rd_hit, wr_low, stopped;
  logic [7:0] wbyte, rbyte;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held_q & w_held_q;
  assign widx = aw_addr_q >> RTC_IDX_SHIFT;
  assign ridx = s_axi_araddr >> RTC_IDX_SHIFT;
  assign wbyte = w_data_q[7:0];
  assign wr_low = do_write & w_strb_q[0];
  assign wr_hit = widx >= RTC_IDX_SEC && widx <= RTC_IDX_IEN;
  assign rd_hit = ridx >= RTC_IDX_SEC && ridx <= RTC_IDX_IEN;
  // time writes while running would race the cascade, so they are dropped
  assign stopped = ~ctrl_q.run_request & ~counting_indicator_q;
  assign clear_now = wr_low && widx == RTC_IDX_CR1 && ctrl_q.soft_clear && !wbyte[RTC_CR_SOFT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RTC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // time and control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_now) begin
      time_q <= '0;
    end else if (busy_q) begin
      time_q <= time_d;
    end else if (wr_low && stopped) begin
      case (widx)
        RTC_IDX_SEC: begin
          time_q.sec_low_digit <= wbyte[3:0];
          time_q.sec_high_digit <= wbyte[6:4];
        end
        RTC_IDX_MIN: begin
          time_q.min_low_digit <= wbyte[3:0];
          time_q.min_high_digit <= wbyte[6:4];
        end
        RTC_IDX_HR: begin
          time_q.hour_low_digit <= wbyte[3:0];
          time_q.hour_high_digit <= wbyte[5:4];
        end
        RTC_IDX_WK: begin
          time_q.weekday_field <= wbyte[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (clear_now) begin
      ctrl_q <= '0;
      // the output gate is outside the soft clear, so the clearing write still sets it
      ctrl_q.clock_out_gate <= wbyte[RTC_CR_GATE];
    end else if (wr_low && widx == RTC_IDX_CR1) begin
      ctrl_q.run_request <= wbyte[RTC_CR_RUN];
      ctrl_q.hour_format_select <= wbyte[RTC_CR_FMT];
      // a hardware toggle in the same cycle wins over the written value
      ctrl_q.afternoon_flag <= (busy_q && pm_d != ctrl_q.afternoon_flag) ? pm_d : wbyte[RTC_CR_PM];
      ctrl_q.soft_clear <= wbyte[RTC_CR_SOFT];
      ctrl_q.int_timing <= wbyte[RTC_CR_INT];
      ctrl_q.clock_out_gate <= wbyte[RTC_CR_GATE];
    end else if (busy_q) begin
      ctrl_q.afternoon_flag <= pm_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear_now) begin
      interrupt_enable_reg <= 6'h00;
    end else if (wr_low && widx == RTC_IDX_IEN) begin
      interrupt_enable_reg <= wbyte[5:0] & RTC_IEN_MASK;
    end
  end

  // square wave from the 8-bit counter top bit, one period per second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= ctrl_q.clock_out_gate & byte_q[BYTE_W-1];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rbyte = RTC_REG_RESET;
    case (ridx)
      RTC_IDX_SEC: rbyte = {busy_q, time_q.sec_high_digit, time_q.sec_low_digit};
      RTC_IDX_MIN: rbyte = {busy_q, time_q.min_high_digit, time_q.min_low_digit};
      RTC_IDX_HR: rbyte = {busy_q, 1'b0, time_q.hour_high_digit, time_q.hour_low_digit};
      RTC_IDX_WK: rbyte = {busy_q, 4'h0, time_q.weekday_field};
      RTC_IDX_CR1: rbyte = {ctrl_q.run_request, ctrl_q.hour_format_select, ctrl_q.afternoon_flag,
        ctrl_q.soft_clear, ctrl_q.int_timing, ctrl_q.clock_out_gate, counting_indicator_q, 1'b0};
      RTC_IDX_IEN: rbyte = {2'h0, interrupt_enable_reg};
      default: rbyte = RTC_REG_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RTC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rbyte};
      s_axi_rresp <= rd_hit ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rtc_tod_counter
`default_nettype wire

/* File: rtc_tod_counter_chk.sv */
// Purpose: bus and register-map assertions for the time-of-day counter
// Assumes: one clock domain, bound to rtc_tod_counter
// Notes: sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module rtc_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [rtc_pkg::RTC_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  import rtc_pkg::*;
  // ****************************************
  // helpers
  // ****************************************
  logic [11:0] idx_q;
  logic unmapped;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_q <= 12'h000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      idx_q <= {2'h0, s_axi_araddr[11:2]};
    end
  end
  assign unmapped = (idx_q < RTC_IDX_SEC) || (idx_q > RTC_IDX_IEN);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  // both channels are parked for one cycle before the response is raised
  write_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("no write response after both channels taken");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("no read data after address taken");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  unmapped_err_a: assert property (s_axi_rvalid && unmapped |-> s_axi_rresp == RTC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_okay_a: assert property (s_axi_rvalid && !unmapped |-> s_axi_rresp == RTC_RESP_OKAY)
    else $error("mapped read refused");
  reserved_zero_a: assert property (s_axi_rvalid |->
    (idx_q != RTC_IDX_CR1 || !s_axi_rdata[0]) && (idx_q != RTC_IDX_WK || s_axi_rdata[6:3] == 4'h0)
    && (idx_q != RTC_IDX_HR || !s_axi_rdata[6])) else $error("unassigned bit reads one");
endmodule : rtc_chk
bind rtc_tod_counter rtc_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* File: rtc_tod_counter_test.sv */
// Purpose: self-checking bench for the time-of-day counter
// Assumes: bench pulses subclock at two aclk cycles a period, so one second costs ~66k cycles
// Notes: only one second elapses, so rollovers start from preset times
`timescale 1ns/1ps
`default_nettype none
module rtc_tod_counter_test;
  import rtc_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } rtc_row_s;
  localparam logic [11:0] A_SEC = RTC_IDX_SEC << RTC_IDX_SHIFT;
  localparam logic [11:0] A_MIN = RTC_IDX_MIN << RTC_IDX_SHIFT;
  localparam logic [11:0] A_HR = RTC_IDX_HR << RTC_IDX_SHIFT;
  localparam logic [11:0] A_WK = RTC_IDX_WK << RTC_IDX_SHIFT;
  localparam logic [11:0] A_CR = RTC_IDX_CR1 << RTC_IDX_SHIFT;
  localparam logic [11:0] A_IEN = RTC_IDX_IEN << RTC_IDX_SHIFT;
  localparam logic [1:0] OK = RTC_RESP_OKAY;
  localparam logic [1:0] ERR = RTC_RESP_SLVERR;
  logic aclk, aresetn, subclock, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tpin;
  logic pin_seen = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [5:0] ien;
  logic [7:0] v;
  int fails, tests_run;
  rtc_row_s rows [10] = '{
    '{1'b0, A_SEC, 8'h00, 8'h00, OK},
    '{1'b0, A_CR, 8'h00, 8'h00, OK},
    '{1'b1, A_SEC, 8'h59, 8'h59, OK},
    '{1'b1, A_MIN, 8'h59, 8'h59, OK},
    '{1'b1, A_HR, 8'hd1, 8'h11, OK},
    '{1'b1, A_WK, 8'hfe, 8'h06, OK},
    '{1'b1, A_IEN, 8'hff, 8'h3f, OK},
    '{1'b1, A_CR, 8'h2f, 8'h2c, OK},
    '{1'b0, 12'h478, 8'h00, 8'h00, ERR},
    '{1'b1, 12'h45c, 8'h55, 8'h00, ERR}
  };

  rtc_tod_counter uut (.aclk(aclk), .aresetn(aresetn), .subclock(subclock), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_output_pin(tpin), .interrupt_enable_reg(ien));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (tpin === 1'b1) pin_seen <= 1'b1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic wrc(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] rs;
    wr(a, d, rs);
    chk({6'h0, rs}, {6'h0, OK});
  endtask : wrc
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] dv;
    logic [1:0] rs;
    rd(a, dv, rs);
    chk(dv, e);
  endtask : rdc
  // subclock moves on aclk edges, so every level is caught even at this pace;
  // the extra edge lines a following read up with the one-cycle busy window
  task automatic sub_pulse(input int k);
    repeat (k) begin
      @(posedge aclk);
      subclock <= 1'b1;
      @(posedge aclk);
      subclock <= 1'b0;
    end
    @(posedge aclk);
  endtask : sub_pulse
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (90000) @(posedge aclk);
    fails++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, subclock} = '0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // ****************************************
    // register table
    // ****************************************
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wd, r);
        chk({6'h0, r}, {6'h0, rows[i].resp});
      end
      rd(rows[i].addr, v, r);
      chk(v, rows[i].rd);
      chk({6'h0, r}, {6'h0, rows[i].resp});
    end
    chk({2'h0, ien}, 8'h3f);
    $display("register table done");
    // ****************************************
    // one second across the second, minute, 12-hour and weekday rollovers
    // ****************************************
    wrc(A_CR, 8'hac);
    rdc(A_CR, 8'hac);
    sub_pulse(4);
    rd(A_CR, v, r);
    chk(v, 8'hae);
    wrc(A_SEC, 8'h00);
    rdc(A_SEC, 8'h59);
    // 8192 counted subclock/4 ticks make one second
    sub_pulse(32768);
    rd(A_SEC, v, r);
    chk(v, 8'hd9);
    rdc(A_SEC, 8'h00);
    rdc(A_MIN, 8'h00);
    rdc(A_HR, 8'h00);
    rdc(A_WK, 8'h00);
    rdc(A_CR, 8'h8e);
    chk({7'h0, pin_seen}, 8'h01);
    $display("rollover done");
    // ****************************************
    // stop, soft clear, 24-hour, second reset
    // ****************************************
    wrc(A_CR, 8'h0c);
    rdc(A_CR, 8'h0e);
    sub_pulse(4);
    rd(A_CR, v, r);
    chk(v, 8'h0c);
    wrc(A_SEC, 8'h33);
    wrc(A_CR, 8'h7c);
    wrc(A_CR, 8'h00);
    rdc(A_SEC, 8'h00);
    rdc(A_IEN, 8'h00);
    chk({2'h0, ien}, 8'h00);
    wrc(A_CR, 8'h40);
    wrc(A_HR, 8'h23);
    rdc(A_HR, 8'h23);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(A_HR, 8'h00);
    rdc(A_CR, 8'h00);
    $display("control tests done");
    test_done();
  end
endmodule : rtc_tod_counter_test
`default_nettype wire
